//--- common/seq_pkg.sv
// Constants and types shared by the program sequencer files
// Behaviour
// [R1] Single-step: each step request runs exactly the successor location, then waits.
// [R2] After each step report executed location, successor, regulation flag, measurements.
// [R3] Output toggle in step mode switches output without leaving step mode.
// [R4] Clear in step mode exits, output held at last executed setpoints.
// [R5] Reset request in step mode exits and reloads power-on defaults.
// [R6] Successor naming earlier location loops endlessly until a stop request.
// [R7] Successor pointer zero ends the sequence after that location completes.
// [R8] On zero-pointer termination output keeps the final location's setpoints.
// [R9] Clear while running lets current interval finish, then stops holding setpoints.
// [R10] Reset request while running stops at once and reloads defaults.
// [R11] Output toggle while running zeroes setpoints, stops, remembers current location.
// [R12] Second output toggle re-applies the remembered location's setpoints.
// [R13] Forty locations, each dwell interval defaulting to ten milliseconds.
// [R14] Location stores current, voltage, both limits, dwell interval, successor.
// [R15] Dwell interval spans ten milliseconds to 655.35 seconds in 10 ms steps.
// [R16] Run request starts at selectable location, dwelling on each before moving.
// [R17] Dwell timer counts 10 ms ticks from clock, advances at stored count.
package seq_pkg;
	localparam int          LOC_COUNT       = 40;
	localparam int          LOC_W           = 6;
	localparam int          SET_W           = 16;
	localparam int          DWELL_W         = 16;
	localparam int          CLK_HZ          = 125000000;
	localparam int          TICK_MS         = 10;
	localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int          TICK_W          = 21;
	localparam logic [15:0] DWELL_DEFAULT   = 16'h0001;
	localparam logic [15:0] DWELL_MIN       = 16'h0001;
	localparam logic [5:0]  LOC_NONE        = 6'h00;
	localparam logic [5:0]  LOC_FIRST       = 6'h01;
	localparam logic [15:0] SET_ZERO        = 16'h0000;
	// Field order inside one stored location word
	typedef struct packed {
		logic [SET_W-1:0]   current_set;
		logic [SET_W-1:0]   voltage_set;
		logic [SET_W-1:0]   overvoltage_limit;
		logic [SET_W-1:0]   overcurrent_limit;
		logic [DWELL_W-1:0] dwell_interval;
		logic [LOC_W-1:0]   successor;
	} loc_s;
	localparam int LOC_BITS = $bits(loc_s);
	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_APPLY, ST_DWELL, ST_STEPWAIT, ST_PAUSED} seq_state_e;
endpackage

//--- common/loc_mem_if.sv
// Carrier between sequencer and location memory
`timescale 1ns/10ps
interface loc_mem_if;
	import seq_pkg::*;
	logic             wr_en;
	logic [LOC_W-1:0] wr_addr;
	loc_s             wr_data;
	logic [LOC_W-1:0] rd_addr;
	loc_s             rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

//--- core/loc_mem.sv
// Forty-location program table with registered read port
`timescale 1ns/10ps
module loc_mem #(
	parameter int DEPTH = seq_pkg::LOC_COUNT
) (
	input wire logic CLK_IN,
	loc_mem_if.mem   bus
);
	import seq_pkg::*;
	// Index 0 is the terminator code; storage spans 0..DEPTH and locations use 1..DEPTH
	loc_s store [0:DEPTH];

	// Writes from the editor port, defaults loaded through that port at reset
	always_ff @(posedge CLK_IN) begin
		if (bus.wr_en) begin
			store[bus.wr_addr] <= bus.wr_data; // see [R14]
		end
	end

	// Registered read
	always_ff @(posedge CLK_IN) begin
		bus.rd_data <= store[bus.rd_addr];
	end
endmodule

//--- core/prog_seq.sv
// Stored-program output sequencer for a programmable DC source
`timescale 1ns/10ps
module prog_seq #(
	parameter int TICK_CYC = seq_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                         CLK_IN,
	input  wire logic                         RST_IN,
	// Front panel keys, one-cycle pulses
	input  wire logic                         RUN_KEY_IN,
	input  wire logic                         STEP_KEY_IN,
	input  wire logic                         CLEAR_KEY_IN,
	input  wire logic                         RESET_KEY_IN,
	input  wire logic                         OUTPUT_KEY_IN,
	input  wire logic [seq_pkg::LOC_W-1:0]    START_LOC_IN,
	// Table editing port
	input  wire logic                         EDIT_WR_IN,
	input  wire logic [seq_pkg::LOC_W-1:0]    EDIT_ADDR_IN,
	input  wire seq_pkg::loc_s                EDIT_DATA_IN,
	// Measurements from the output stage
	input  wire logic [seq_pkg::SET_W-1:0]    MEAS_V_IN,
	input  wire logic [seq_pkg::SET_W-1:0]    MEAS_I_IN,
	input  wire logic                         CV_MODE_IN,
	// Setpoints to the output stage
	output logic [seq_pkg::SET_W-1:0]         CURRENT_SET_OUT,
	output logic [seq_pkg::SET_W-1:0]         VOLTAGE_SET_OUT,
	output logic [seq_pkg::SET_W-1:0]         OVERVOLTAGE_LIMIT_OUT,
	output logic [seq_pkg::SET_W-1:0]         OVERCURRENT_LIMIT_OUT,
	output logic                              OUTPUT_ON_OUT,
	// Status display
	output logic                              RUNNING_OUT,
	output logic                              STEP_MODE_OUT,
	output logic                              STEP_DONE_OUT,
	output logic [seq_pkg::LOC_W-1:0]         EXEC_LOC_OUT,
	output logic [seq_pkg::LOC_W-1:0]         NEXT_LOC_OUT,
	output logic                              CONSTANT_VOLTAGE_FLAG_OUT,
	output logic                              CONSTANT_CURRENT_FLAG_OUT,
	output logic [seq_pkg::SET_W-1:0]         MEAS_V_OUT,
	output logic [seq_pkg::SET_W-1:0]         MEAS_I_OUT
);
	import seq_pkg::*;

	loc_mem_if mbus ();
	loc_mem #(.DEPTH(LOC_COUNT)) u_mem (.CLK_IN(CLK_IN), .bus(mbus.mem));

	seq_state_e       state_r;
	logic             step_mode_r;
	logic             clear_pend_r;
	logic             cycle_step_r;
	logic [LOC_W-1:0] cur_loc_r;
	loc_s             cur_r;
	logic [TICK_W-1:0] tick_cnt_r;
	logic             tick_r;
	logic [DWELL_W-1:0] dwell_cnt_r;
	logic [LOC_W-1:0] init_addr_r;
	logic             init_r;
	loc_s             dflt;

	// Power-on default content: zero setpoints, 10 ms dwell, no successor
	always_comb begin
		dflt                = '0;
		dflt.dwell_interval = DWELL_DEFAULT; // see [R13]
		dflt.successor      = LOC_NONE;
	end

	// Reset walks every location back to its default, one per cycle
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			init_r      <= 1'b1;
			init_addr_r <= LOC_FIRST;
		end else if (init_r) begin
			if (init_addr_r == LOC_W'(LOC_COUNT)) begin
				init_r <= 1'b0; // see [R13]
			end
			init_addr_r <= init_addr_r + 6'h01;
		end
	end

	assign mbus.wr_en   = init_r | EDIT_WR_IN;
	assign mbus.wr_addr = init_r ? init_addr_r : EDIT_ADDR_IN;
	assign mbus.wr_data = init_r ? dflt : EDIT_DATA_IN;
	assign mbus.rd_addr = cur_loc_r;

	// 10 ms tick divider, free running, restarted at each new location
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || state_r == ST_APPLY) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1; // see [R17]
		end else begin
			tick_cnt_r <= tick_cnt_r + 21'h000001;
			tick_r     <= 1'b0;
		end
	end

	// Dwell counter in 10 ms units; a stored zero is treated as the minimum
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			dwell_cnt_r <= '0;
		end else if (state_r == ST_APPLY) begin
			dwell_cnt_r <= '0;
		end else if (state_r == ST_DWELL && tick_r) begin
			dwell_cnt_r <= dwell_cnt_r + 16'h0001; // see [R15]
		end
	end

	logic [DWELL_W-1:0] dwell_lim;
	logic               dwell_done;
	assign dwell_lim  = (cur_r.dwell_interval < DWELL_MIN) ? DWELL_MIN : cur_r.dwell_interval;
	assign dwell_done = (state_r == ST_DWELL) && tick_r && (dwell_cnt_r + 16'h0001 >= dwell_lim); // see [R17]

	// Sequencer state. Reset key outranks the toggle, which outranks clear.
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || init_r || RESET_KEY_IN) begin
			state_r      <= ST_IDLE; // see [R5] see [R10]
			step_mode_r  <= 1'b0;
			clear_pend_r <= 1'b0;
			cycle_step_r <= 1'b0;
			cur_loc_r    <= LOC_FIRST;
			cur_r        <= dflt;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (RUN_KEY_IN || STEP_KEY_IN) begin
						cur_loc_r    <= (START_LOC_IN == LOC_NONE) ? LOC_FIRST : START_LOC_IN; // see [R16]
						step_mode_r  <= STEP_KEY_IN & ~RUN_KEY_IN;
						clear_pend_r <= 1'b0;
						state_r      <= ST_FETCH;
					end
				end
				// One cycle for the registered memory read
				// Clear keys in the two lead-in cycles are kept, so a stop is never lost
				ST_FETCH: begin
					state_r      <= (OUTPUT_KEY_IN && !step_mode_r) ? ST_PAUSED : ST_APPLY; // see [R11]
					clear_pend_r <= clear_pend_r | CLEAR_KEY_IN; // see [R9]
				end
				ST_APPLY: begin
					cur_r        <= mbus.rd_data;
					clear_pend_r <= clear_pend_r | CLEAR_KEY_IN; // see [R9]
					if (OUTPUT_KEY_IN && !step_mode_r) begin
						state_r <= ST_PAUSED; // see [R11]
					end else begin
						state_r <= step_mode_r ? ST_STEPWAIT : ST_DWELL; // see [R1]
					end
				end
				ST_DWELL: begin
					if (OUTPUT_KEY_IN) begin
						state_r <= ST_PAUSED; // see [R11]
					end else if (dwell_done) begin
						if (clear_pend_r || CLEAR_KEY_IN || cur_r.successor == LOC_NONE) begin
							state_r <= ST_IDLE; // see [R7] see [R8] see [R9]
						end else begin
							cur_loc_r <= cur_r.successor; // see [R6]
							state_r   <= ST_FETCH;
						end
					end else if (CLEAR_KEY_IN) begin
						clear_pend_r <= 1'b1; // see [R9]
					end
				end
				// Waiting for the next step key
				ST_STEPWAIT: begin
					if (CLEAR_KEY_IN || clear_pend_r) begin
						state_r     <= ST_IDLE; // see [R4]
						step_mode_r <= 1'b0;
					end else if (STEP_KEY_IN) begin
						if (cur_r.successor == LOC_NONE) begin
							state_r     <= ST_IDLE; // see [R7]
							step_mode_r <= 1'b0;
						end else begin
							cur_loc_r <= cur_r.successor; // see [R1]
							state_r   <= ST_FETCH;
						end
					end
				end
				// Stopped by the toggle; the remembered location is cur_r
				ST_PAUSED: begin
					if (OUTPUT_KEY_IN) begin
						state_r <= ST_IDLE; // see [R12]
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Output enable; toggles freely except the pause path which forces it
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || init_r || RESET_KEY_IN) begin
			OUTPUT_ON_OUT <= 1'b0;
		end else if ((state_r == ST_FETCH || state_r == ST_APPLY || state_r == ST_DWELL) && !step_mode_r && OUTPUT_KEY_IN) begin
			OUTPUT_ON_OUT <= 1'b0; // see [R11]
		end else if (state_r == ST_PAUSED && OUTPUT_KEY_IN) begin
			OUTPUT_ON_OUT <= 1'b1; // see [R12]
		end else if (OUTPUT_KEY_IN) begin
			OUTPUT_ON_OUT <= ~OUTPUT_ON_OUT; // see [R3]
		end
	end

	// Setpoints follow the active location; zero while the output is off
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || !OUTPUT_ON_OUT) begin
			CURRENT_SET_OUT       <= SET_ZERO;
			VOLTAGE_SET_OUT       <= SET_ZERO;
			OVERVOLTAGE_LIMIT_OUT <= SET_ZERO;
			OVERCURRENT_LIMIT_OUT <= SET_ZERO;
		end else begin
			CURRENT_SET_OUT       <= cur_r.current_set; // see [R8] see [R4]
			VOLTAGE_SET_OUT       <= cur_r.voltage_set;
			OVERVOLTAGE_LIMIT_OUT <= cur_r.overvoltage_limit;
			OVERCURRENT_LIMIT_OUT <= cur_r.overcurrent_limit;
		end
	end

	// Status display; report is latched each time a location is applied, in step or run mode
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			RUNNING_OUT               <= 1'b0;
			STEP_MODE_OUT             <= 1'b0;
			STEP_DONE_OUT             <= 1'b0;
			EXEC_LOC_OUT              <= LOC_NONE;
			NEXT_LOC_OUT              <= LOC_NONE;
			CONSTANT_VOLTAGE_FLAG_OUT <= 1'b0;
			CONSTANT_CURRENT_FLAG_OUT <= 1'b0;
			MEAS_V_OUT                <= SET_ZERO;
			MEAS_I_OUT                <= SET_ZERO;
		end else begin
			RUNNING_OUT   <= (state_r == ST_FETCH || state_r == ST_APPLY || state_r == ST_DWELL) && !step_mode_r;
			STEP_MODE_OUT <= step_mode_r;
			STEP_DONE_OUT <= (state_r == ST_APPLY) && step_mode_r;
			if (state_r == ST_APPLY) begin
				EXEC_LOC_OUT              <= cur_loc_r; // see [R2]
				NEXT_LOC_OUT              <= mbus.rd_data.successor;
				CONSTANT_VOLTAGE_FLAG_OUT <= CV_MODE_IN;
				CONSTANT_CURRENT_FLAG_OUT <= ~CV_MODE_IN;
				MEAS_V_OUT                <= MEAS_V_IN;
				MEAS_I_OUT                <= MEAS_I_IN;
			end
		end
	end

	// A step lands exactly three cycles after the step key in the wait state
	AST_STEP_ONE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R1]
		(state_r == ST_STEPWAIT && STEP_KEY_IN && !CLEAR_KEY_IN && !clear_pend_r && !RESET_KEY_IN
		&& cur_r.successor != LOC_NONE)
		|=> state_r == ST_FETCH ##1 state_r == ST_APPLY ##1 state_r == ST_STEPWAIT)
		else $error("Step did not execute one location");
	AST_STEP_REPORT: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R2]
		(state_r == ST_APPLY && step_mode_r && !RESET_KEY_IN) |=> STEP_DONE_OUT && EXEC_LOC_OUT == $past(cur_loc_r))
		else $error("Step report wrong");
	AST_STEP_TOGGLE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R3]
		(state_r == ST_STEPWAIT && OUTPUT_KEY_IN && !CLEAR_KEY_IN && !clear_pend_r && !STEP_KEY_IN && !RESET_KEY_IN)
		|=> state_r == ST_STEPWAIT && OUTPUT_ON_OUT != $past(OUTPUT_ON_OUT))
		else $error("Toggle in step mode misbehaved");
	AST_STEP_CLEAR: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R4]
		(state_r == ST_STEPWAIT && CLEAR_KEY_IN && !RESET_KEY_IN) |=> state_r == ST_IDLE && !step_mode_r && $stable(cur_r))
		else $error("Clear in step mode did not hold setpoints");
	AST_RESET_KEY: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R5] see [R10]
		RESET_KEY_IN |=> state_r == ST_IDLE && !OUTPUT_ON_OUT && cur_r == dflt)
		else $error("Reset key did not restore defaults");
	AST_LOOP: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R6]
		(dwell_done && !OUTPUT_KEY_IN && !CLEAR_KEY_IN && !clear_pend_r && !RESET_KEY_IN && cur_r.successor != LOC_NONE)
		|=> cur_loc_r == $past(cur_r.successor) && state_r == ST_FETCH)
		else $error("Successor not followed");
	AST_TERMINATE: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R7] see [R8]
		(dwell_done && !OUTPUT_KEY_IN && !RESET_KEY_IN && cur_r.successor == LOC_NONE)
		|=> state_r == ST_IDLE && $stable(cur_r))
		else $error("Zero successor did not stop sequence");
	AST_CLEAR_FINISH: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R9]
		(state_r == ST_DWELL && CLEAR_KEY_IN && !dwell_done && !OUTPUT_KEY_IN && !RESET_KEY_IN) |=> state_r == ST_DWELL)
		else $error("Clear cut the step short");
	AST_TOGGLE_STOP: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R11]
		(state_r == ST_DWELL && OUTPUT_KEY_IN && !RESET_KEY_IN) |=> state_r == ST_PAUSED ##1 CURRENT_SET_OUT == SET_ZERO)
		else $error("Toggle did not stop and zero output");
	AST_TOGGLE_RESUME: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see [R12]
		(state_r == ST_PAUSED && OUTPUT_KEY_IN && !RESET_KEY_IN) |=> ##1 VOLTAGE_SET_OUT == cur_r.voltage_set)
		else $error("Second toggle did not restore setpoints");
endmodule

//--- sim/panel_model.sv
// Front panel model: key pulses out, step report captured in
`timescale 1ns/10ps
module panel_model (
	// Clock
	input  wire logic        CLK_IN,
	// Status display
	input  wire logic        STEP_DONE_IN,
	input  wire logic [5:0]  EXEC_LOC_IN,
	input  wire logic [5:0]  NEXT_LOC_IN,
	input  wire logic        CV_FLAG_IN,
	input  wire logic        CC_FLAG_IN,
	input  wire logic [15:0] MEAS_V_IN,
	input  wire logic [15:0] MEAS_I_IN,
	// Keys: bit 0 run, 1 step, 2 clear, 3 reset, 4 output toggle
	output logic      [4:0]  KEYS_OUT,
	output logic      [5:0]  START_LOC_OUT
);
	logic [5:0]  rep_exec;
	logic [5:0]  rep_next;
	logic        rep_cv;
	logic        rep_cc;
	logic [15:0] rep_v;
	logic [15:0] rep_i;

	initial begin
		KEYS_OUT = 5'h00;
		START_LOC_OUT = 6'h00;
	end

	// Latch the report mid-cycle so it never races the launching edge
	always @(negedge CLK_IN) begin
		if (STEP_DONE_IN === 1'b1) begin
			rep_exec <= EXEC_LOC_IN;
			rep_next <= NEXT_LOC_IN;
			rep_cv   <= CV_FLAG_IN;
			rep_cc   <= CC_FLAG_IN;
			rep_v    <= MEAS_V_IN;
			rep_i    <= MEAS_I_IN;
		end
	end

	// One-cycle key pulse, then the four idle cycles the sequencer needs between keys
	task automatic press(input int k, input logic [5:0] loc);
		@(negedge CLK_IN);
		START_LOC_OUT = loc;
		KEYS_OUT = 5'h01 << k;
		@(negedge CLK_IN);
		KEYS_OUT = 5'h00;
		repeat (4) @(negedge CLK_IN);
	endtask
endmodule

//--- sim/prog_seq_tb_top.sv
// Self-checking bench for the program sequencer
`timescale 1ns/10ps
module prog_seq_tb_top;
	import seq_pkg::*;
	localparam int TICK = 10;
	logic clk, rst, edit_wr, cv_in, run_k, step_k, clr_k, rst_k, out_k;
	logic [5:0] start_loc, edit_addr, held;
	logic [15:0] mv, mi, cur_o, vol_o, ov_o, oc_o, mv_o, mi_o;
	logic out_on, running, step_mode, step_done, cv_o, cc_o;
	logic [5:0] exec_o, next_o;
	loc_s edit_data;
	loc_s tbl [1:40];
	int err_total, n_tests, span;

	prog_seq #(.TICK_CYC(TICK)) dut (.CLK_IN(clk), .RST_IN(rst), .RUN_KEY_IN(run_k), .STEP_KEY_IN(step_k),
		.CLEAR_KEY_IN(clr_k), .RESET_KEY_IN(rst_k), .OUTPUT_KEY_IN(out_k), .START_LOC_IN(start_loc),
		.EDIT_WR_IN(edit_wr), .EDIT_ADDR_IN(edit_addr), .EDIT_DATA_IN(edit_data), .MEAS_V_IN(mv),
		.MEAS_I_IN(mi), .CV_MODE_IN(cv_in), .CURRENT_SET_OUT(cur_o), .VOLTAGE_SET_OUT(vol_o),
		.OVERVOLTAGE_LIMIT_OUT(ov_o), .OVERCURRENT_LIMIT_OUT(oc_o), .OUTPUT_ON_OUT(out_on),
		.RUNNING_OUT(running), .STEP_MODE_OUT(step_mode), .STEP_DONE_OUT(step_done), .EXEC_LOC_OUT(exec_o),
		.NEXT_LOC_OUT(next_o), .CONSTANT_VOLTAGE_FLAG_OUT(cv_o), .CONSTANT_CURRENT_FLAG_OUT(cc_o),
		.MEAS_V_OUT(mv_o), .MEAS_I_OUT(mi_o));

	panel_model panel (.CLK_IN(clk), .STEP_DONE_IN(step_done), .EXEC_LOC_IN(exec_o), .NEXT_LOC_IN(next_o),
		.CV_FLAG_IN(cv_o), .CC_FLAG_IN(cc_o), .MEAS_V_IN(mv_o), .MEAS_I_IN(mi_o),
		.KEYS_OUT({out_k, rst_k, clr_k, step_k, run_k}), .START_LOC_OUT(start_loc));

	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test();
		$display("mismatches %0d of %0d checks", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		chk16(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	// All four setpoints of one stored location
	task automatic chk_set(input loc_s l);
		chk16("current setpoint", l.current_set, cur_o);
		chk16("voltage setpoint", l.voltage_set, vol_o);
		chk16("overvoltage limit", l.overvoltage_limit, ov_o);
		chk16("overcurrent limit", l.overcurrent_limit, oc_o);
	endtask

	// Random location; dwell of 2 or 3 ticks keeps runs short
	task automatic edit(input logic [5:0] a, input logic [5:0] succ);
		tbl[a] = '{16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
			16'h0002 + 16'($urandom_range(1)), succ};
		@(negedge clk);
		edit_wr = 1'b1;
		edit_addr = a;
		edit_data = tbl[a];
		@(negedge clk);
		edit_wr = 1'b0;
	endtask

	// One step with fresh measurements; report and setpoints compared
	task automatic do_step(input logic [5:0] loc, input logic [5:0] nxt);
		mv = 16'($urandom);
		mi = 16'($urandom);
		cv_in = 1'($urandom);
		panel.press(1, loc);
		chk16("executed location", {10'h000, loc}, {10'h000, panel.rep_exec});
		chk16("next location", {10'h000, nxt}, {10'h000, panel.rep_next});
		chkb("cv flag", cv_in, panel.rep_cv);
		chkb("cc flag", ~cv_in, panel.rep_cc);
		chk16("measured voltage", mv, panel.rep_v);
		chk16("measured current", mi, panel.rep_i);
		chkb("step mode", 1'b1, step_mode);
		chk_set(tbl[loc]);
	endtask

	// Bounded wait for the sequence to stop; returns cycles waited
	task automatic wait_idle(input int bound);
		span = 0;
		while (running !== 1'b0) begin
			@(negedge clk);
			span++;
			if (span > bound) begin
				err_total++;
				$display("wrong value running expected 0 seen 1");
				end_of_test();
			end
		end
	endtask

	initial begin
		{edit_wr, cv_in} = 2'b00;
		{edit_addr, mv, mi} = '0;
		edit_data = '0;
		err_total = 0;
		n_tests = 0;
		void'($urandom(32'h71EE73D2));
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (42) @(negedge clk);
		// Chain 1 -> 40 -> 3 -> end, using the top location as a boundary
		edit(6'h01, 6'h28);
		edit(6'h28, 6'h03);
		edit(6'h03, 6'h00);
		panel.press(4, 6'h00);
		chkb("output on", 1'b1, out_on);
		do_step(6'h01, 6'h28);
		do_step(6'h28, 6'h03);
		panel.press(4, 6'h00);
		chkb("step mode", 1'b1, step_mode);
		chk16("current off", 16'h0000, cur_o);
		panel.press(4, 6'h00);
		chk_set(tbl[40]);
		panel.press(2, 6'h00);
		chkb("step mode", 1'b0, step_mode);
		chk_set(tbl[40]);
		do_step(6'h03, 6'h00);
		panel.press(3, 6'h00);
		chkb("step mode", 1'b0, step_mode);
		chkb("output on", 1'b0, out_on);
		chk16("current default", 16'h0000, cur_o);
		// Run once: dwell honoured, output stays at the last location
		panel.press(4, 6'h00);
		panel.press(0, 6'h01);
		chkb("running", 1'b1, running);
		wait_idle(TICK * 9 + 40);
		chkb("dwell respected", 1'b1, span + 6 >= TICK * int'(tbl[1].dwell_interval + tbl[40].dwell_interval
			+ tbl[3].dwell_interval));
		chk16("final location", 16'h0003, {10'h000, exec_o});
		chk_set(tbl[3]);
		// Endless loop, start location 0 selects 1, then clear finishes the step
		edit(6'h03, 6'h01);
		panel.press(0, 6'h00);
		repeat (TICK * 20) @(negedge clk);
		chkb("still looping", 1'b1, running);
		panel.press(2, 6'h00);
		wait_idle(TICK * 3 + 10);
		chk_set(tbl[exec_o]);
		// Reset key stops at once
		panel.press(0, 6'h01);
		panel.press(3, 6'h00);
		chkb("running", 1'b0, running);
		chkb("output on", 1'b0, out_on);
		// Output toggle stops and zeroes; the frozen report names the remembered location
		panel.press(4, 6'h00);
		panel.press(0, 6'h01);
		repeat (TICK * 2 + 3) @(negedge clk);
		panel.press(4, 6'h00);
		held = exec_o;
		chkb("running", 1'b0, running);
		chk16("current off", 16'h0000, cur_o);
		chk16("voltage off", 16'h0000, vol_o);
		panel.press(4, 6'h00);
		chk_set(tbl[held]);
		chkb("running", 1'b0, running);
		end_of_test();
	end
endmodule
